// ===== bench/scu_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------
// Port checker of the serial unit
// ------------------------------------------------
module scu_chk (
    input wire logic        ref_clk, nrst, psel, penable, pready, pslverr,
    input wire logic        rx_req0, tx_req0, second_channel_irq_out,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic [1:0]  rxd_out, rxd_oe_n, txd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_low; $fell(txd[0]) |=> !txd[0] ##1 txd[0]; endproperty
    a_low: assert property (p_low) else $error("txd low span");
    property p_go; $fell(rxd_oe_n[0]) |-> txd[0]; endproperty
    a_go: assert property (p_go) else $error("txd low at start");
    property p_bit;
        $changed(rxd_out[0]) && !rxd_oe_n[0] && !$past(rxd_oe_n[0])
        |-> $past(txd[0]) && !$past(txd[0], 2);
    endproperty
    a_bit: assert property (p_bit) else $error("rxd off txd rise");
    property p_tx; tx_req0 |=> !tx_req0; endproperty
    a_tx: assert property (p_tx) else $error("tx request long");
    property p_rx; rx_req0 |=> !rx_req0; endproperty
    a_rx: assert property (p_rx) else $error("rx request long");
    // Only a finished access to the second status word may drop the pin
    property p_clr; $fell(second_channel_irq_out)
        |-> $past(pready, 2) && $past(paddr, 2) == 8'h24; endproperty
    a_clr: assert property (p_clr) else $error("irq dropped alone");
    property p_wt; psel && penable && !pready |=> pready; endproperty
    a_wt: assert property (p_wt) else $error("wait state count");
    property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("error reply");
    c_tx: cover property (tx_req0);
    c_rx: cover property (rx_req0);
    c_irq: cover property ($fell(second_channel_irq_out));
endmodule // scu_chk
bind scu_top scu_chk u_chk (.ref_clk, .nrst, .psel, .penable, .pready,
    .pslverr, .rx_req0, .tx_req0, .second_channel_irq_out, .paddr, .prdata,
    .rxd_out, .rxd_oe_n, .txd);

// ===== bench/scu_peer.sv
`timescale 1ns/10ps
// ------------------------------------------------
// Far-side shift register of one channel
// ------------------------------------------------
module scu_peer (
    input wire logic       txd, oe_n, dev_out, en, load,
    input wire logic [7:0] tx_byte,
    output logic           line,
    output logic [7:0]     got
);
    logic [7:0] sh; // Bits still to send, LSB first
    // stable across rise
    // Released line with en low shows the inverse, so a stale bit never matches
    assign line = !oe_n ? dev_out : en ? sh[0] : ~dev_out;
    always @(posedge txd or posedge load)
        if (load) sh <= tx_byte;
        else if (!oe_n) got <= {line, got[7:1]};
        else if (en) sh <= sh >> 1;
endmodule // scu_peer

// ===== bench/serial_unit_sync_mode_and_irq_tb_top.sv
`timescale 1ns/10ps
module serial_unit_sync_mode_and_irq_tb_top;
    logic        ref_clk, nrst, psel, penable, pwrite, ld0, en0, err;
    logic        pready, pslverr, rx_req0, tx_req0, irq;
    logic [7:0]  paddr, b0, b1, g0, g1;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  cts_n, bclk, rxd_out, rxd_oe_n, txd;
    wire  [1:0]  rxd_in;
    wire  [2:0]  ev = {irq, rx_req0, tx_req0};
    int          err_total, num_checks, n;
    scu_top dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cts_n, .bclk, .rxd_in, .rxd_out,
        .rxd_oe_n, .txd, .rx_req0, .tx_req0, .second_channel_irq_out(irq));
    scu_peer p0 (.txd(txd[0]), .oe_n(rxd_oe_n[0]), .dev_out(rxd_out[0]),
        .en(en0), .load(ld0), .tx_byte(b0), .line(rxd_in[0]), .got(g0));
    scu_peer p1 (.txd(txd[1]), .oe_n(rxd_oe_n[1]), .dev_out(rxd_out[1]),
        .en(1'b0), .load(1'b0), .tx_byte(8'h00), .line(rxd_in[1]), .got(g1));
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp); end
    endtask
    // One APB transfer, request held until pready is seen high
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {r, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wt(input int s);
        for (n = 0; n < 4000 && ev[s] !== 1'b1; n++) @(posedge ref_clk);
        if (n >= 4000) err_total++;
    endtask
    // Expected status word; all-empty stands whenever the channel idles
    function automatic logic [31:0] sts(input logic rd, td);
        return {25'h0, rd, td, 2'b01, 3'h0};
    endfunction
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    initial forever #80 bclk = ~bclk;
    initial begin #300000; err_total++; print_verdict(); end
    initial begin
        {ref_clk, bclk, psel, penable, pwrite, ld0, en0, nrst} = '0;
        {paddr, pwdata, err_total, num_checks} = '0;
        cts_n = 2'b11;
        b0 = 8'($urandom(75776));
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        apb(0, 8'h04, 0); chk(r, sts(0, 0));
        apb(0, 8'h18, 0); chk({r[30:0], err}, 32'h0000_0001);
        apb(1, 8'h10, 32'h0000_8003);
        apb(1, 8'h00, 32'h0000_0040);
        cts_n[0] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cts_n[0] <= 1'b1;
        apb(1, 8'h08, {24'h0, b0});
        repeat (20) @(posedge ref_clk);
        chk(32'(rxd_oe_n), 32'h0000_0003);
        cts_n[0] <= 1'b0;
        wt(0); chk(32'(g0), 32'(b0));
        apb(0, 8'h04, 0); chk(r, sts(0, 1));
        b1 = 8'($urandom);
        apb(1, 8'h30, 32'h0000_0002);
        apb(1, 8'h28, {24'h0, b1});
        wt(2); chk(32'(g1), 32'(b1));
        apb(0, 8'h24, 0); chk(r, sts(0, 1));
        repeat (2) @(posedge ref_clk);
        chk(32'(irq), 32'h0000_0000);
        apb(0, 8'h24, 0); chk(r, sts(0, 0));
        b0 = 8'($urandom);
        {ld0, en0} <= 2'b11;
        @(posedge ref_clk);
        ld0 <= 1'b0;
        apb(1, 8'h00, 32'h0000_0020);
        wt(1);
        apb(1, 8'h00, 0);
        en0 <= 1'b0;
        apb(0, 8'h0C, 0); chk(r, {24'h0, b0});
        apb(0, 8'h04, 0); chk(r, sts(1, 1));
        apb(1, 8'h20, 32'h0000_0080);
        repeat (2) @(posedge ref_clk);
        chk(32'(txd), 32'h0000_0001);
        print_verdict();
    end
endmodule // serial_unit_sync_mode_and_irq_tb_top

// ===== hw/scu_defines.svh
// Function
// (RQ1) Software selects mode zero, optional clear-to-send gate
// (RQ2) Holding buffer write starts transmit; flags track
// (RQ3) Receive starts on enable with done clear
// (RQ4) Async error and break flags meaningless here
// (RQ5) Force-line-low independent of shifting
// (RQ6) Clear-to-send counts only after buffer write arms
// (RQ7) Clear-to-send synchronised before serial logic
// (RQ8) Sender holds clear-to-send 1.5 clocks minimum
// (RQ9) Baud clock low-then-high bumps baud counter
// (RQ10) Baud clock at most half system clock
// (RQ11) TXD always driven; RXD driven only transmitting
// (RQ12) System timebase: low two, high compare-1
// (RQ13) Software never loads compare of one
// (RQ14) RXD changes after each TXD rise
// (RQ15) Sender keeps RXD stable at TXD rise
// (RQ16) Baud clock timebase: low 4.5 clocks after match
// (RQ17) All TXD edges aligned to system clock
// (RQ18) Channel zero reception pulses request, sets flag
// (RQ19) Channel zero transmission pulses request, sets flag
// (RQ20) Channel one flags ORed onto interrupt pin
// (RQ21) Channel one status read clears both flags
// (RQ22) Mode code zero selects synchronous shift
// (RQ23) All-empty flag resets one, read keeps it
// (RQ24) Eight bits, LSB first, one per TXD period
`ifndef SCU_DEFINES_SVH
`define SCU_DEFINES_SVH

// ----------------------------------------------------------------
// Register map, word index inside one channel window
// ----------------------------------------------------------------
`define SCU_OFS_CTRL     3'h0
`define SCU_OFS_STAT     3'h1
`define SCU_OFS_TBUF     3'h2
`define SCU_OFS_RBUF     3'h3
`define SCU_OFS_CMP      3'h4
`define SCU_OFS_CNT      3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCU_CTRL_REN     5
`define SCU_CTRL_GATE    6
`define SCU_CTRL_BRK     7
`define SCU_STAT_EMP     3
`define SCU_STAT_TDN     5
`define SCU_STAT_RDN     6
`define SCU_CMP_SYSCLK   15

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SCU_MODE_SYNC    3'h0
`define SCU_CMP_RST      16'h0000
`define SCU_TXE_RST      1'b1

// ----------------------------------------------------------------
// Timing counts in system clocks, and bits per frame
// ----------------------------------------------------------------
`define SCU_LOW_CYC      16'h0002
`define SCU_BCLK_DLY     3'h4
`define SCU_BITS         4'h8

`endif

// ===== hw/scu_pin_if.sv
`timescale 1ns/10ps
// Synchronised pin view handed from the sampler to the channels
interface scu_pin_if;
    logic [1:0] cts_lvl;    // Clear-to-send asserted, synchronised
    logic [1:0] bclk_rise;  // One-cycle pulse per baud clock rise
    logic [1:0] rxd_lvl;    // Receive line, synchronised
    modport drv (output cts_lvl, output bclk_rise, output rxd_lvl);
    modport use_p (input cts_lvl, input bclk_rise, input rxd_lvl);
endinterface // scu_pin_if

// ===== hw/scu_pkg.sv
package scu_pkg;
    // Channel sequencer states, Gray along idle-wait-shift
    typedef enum logic [1:0] {
        SCU_IDLE = 2'b00,
        SCU_CTSW = 2'b01,
        SCU_TX   = 2'b11,
        SCU_RX   = 2'b10
    } scu_state_t;
endpackage

// ===== hw/scu_sync.sv
`timescale 1ns/10ps
module scu_sync (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic [1:0] cts_n_pin,
    input  wire logic [1:0] bclk_pin,
    input  wire logic [1:0] rxd_pin,
    scu_pin_if.drv          pins
);
    // ----------------------------------------------------------------
    // Two-stage samplers
    // ----------------------------------------------------------------
    logic [5:0] meta_ff;   // First stage, read only by second stage
    logic [5:0] sync_ff;   // Second stage, safe to use
    logic [1:0] bclk_d_ff; // Previous baud clock level for edges

    // (RQ7) sample then settle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 6'h3f;
            sync_ff <= 6'h3f;
        end else begin
            meta_ff <= {rxd_pin, bclk_pin, cts_n_pin};
            sync_ff <= meta_ff;
        end
    end

    // Edge memory for the baud clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bclk_d_ff <= 2'h3;
        end else begin
            bclk_d_ff <= sync_ff[3:2];
        end
    end

    // Pin is active low, so invert for an asserted level
    assign pins.cts_lvl   = ~sync_ff[1:0];
    // (RQ9) low then high
    assign pins.bclk_rise = sync_ff[3:2] & ~bclk_d_ff;
    assign pins.rxd_lvl   = sync_ff[5:4];
endmodule // scu_sync

// ===== hw/scu_top.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "scu_defines.svh"
module scu_top
    import scu_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  cts_n,
    input  wire logic [1:0]  bclk,
    input  wire logic [1:0]  rxd_in,
    output logic [1:0]       rxd_out,
    output logic [1:0]       rxd_oe_n,
    output logic [1:0]       txd,
    output logic             rx_req0,
    output logic             tx_req0,
    output logic             second_channel_irq_out
);
    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    scu_pin_if pin_if ();

    scu_sync u_sync (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .cts_n_pin (cts_n),
        .bclk_pin  (bclk),
        .rxd_pin   (rxd_in),
        .pins      (pin_if.drv)
    );

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic        pready_ff;   // Access phase answer, one wait state
    logic        pslverr_ff;  // Unmapped address flag
    logic [31:0] prdata_ff;   // Read data captured with pready
    logic        apb_done;    // Completing access edge
    logic        mapped;      // Address lands on a register
    logic [31:0] rd_word [2]; // Per-channel read view
    logic [31:0] nxt_prdata;  // Selected read word
    logic [1:0]  txd_ff;      // Shift clock pins
    logic [1:0]  rxd_out_ff;  // Transmit data pins
    logic [1:0]  rxd_oe_n_ff; // Low while driving RXD
    logic [1:0]  rx_req_ff;   // Reception pulses
    logic [1:0]  tx_req_ff;   // Transmission pulses
    logic [1:0]  rdn_ff;      // Receive done flags
    logic [1:0]  tdn_ff;      // Transmit done flags
    logic        irq1_ff;     // Channel one interrupt pin

    assign apb_done = psel & penable & pready_ff;
    assign mapped   = (paddr[7:6] == 2'h0) && (paddr[4:2] <= `SCU_OFS_CNT);
    assign nxt_prdata = rd_word[paddr[5]];

    // Answer on the second access cycle; reads are sampled then
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
            if (psel & penable & ~pready_ff) begin
                prdata_ff <= mapped ? nxt_prdata : 32'h0000_0000;
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic        wr_en;      // Write completing to this channel
            logic        rd_en;      // Read completing to this channel
            logic [2:0]  mode_ff;    // Mode select field
            logic        ren_ff;     // Receive enable
            logic        gate_ff;    // Clear-to-send gate enable
            logic        brk_ff;     // Force line low
            logic [15:0] cmp_ff;     // Compare and timebase select
            logic [14:0] bcnt_ff;    // Baud counter
            logic [7:0]  tbuf_ff;    // Transmit holding buffer
            logic        tfull_ff;   // Holding buffer occupied
            logic        armed_ff;   // Clear-to-send sense armed
            logic [7:0]  rbuf_ff;    // Receive holding buffer
            logic [7:0]  sh_ff;      // Shift register
            logic [3:0]  bits_ff;    // Bits shifted so far
            logic        low_ff;     // Shift clock in low phase
            logic [15:0] ph_ff;      // Cycles spent in this phase
            logic [2:0]  dly_ff;     // Low-start delay, baud clock base
            logic        dly_run_ff; // Delay is counting
            scu_state_t  st_ff;      // Sequencer state
            scu_state_t  nxt_st;     // Next sequencer state
            logic        sync_mode;  // Synchronous shift selected
            logic        active;     // Shifting in either direction
            logic        hi_end;     // High phase finished
            logic        lo_end;     // Low phase finished
            logic        rise;       // Shift clock rises this edge
            logic        rise_d_ff;  // Cycle after the rise
            logic        last;       // Final bit period ends
            logic        bmatch;     // Baud counter hits compare
            logic [15:0] hi_len;     // High phase length in cycles
            logic        empty;      // Buffer and shifter both empty

            assign wr_en = apb_done & pwrite & (paddr[5] == ch);
            assign rd_en = apb_done & ~pwrite & (paddr[5] == ch);
            // (RQ22) code zero
            assign sync_mode = (mode_ff == `SCU_MODE_SYNC);
            assign active = (st_ff == SCU_TX) || (st_ff == SCU_RX);
            // Compare below two is illegal; clamp so timing stays sane
            assign hi_len = (cmp_ff[14:0] < 15'h0002) ? 16'h0001 :
                            {1'b0, cmp_ff[14:0]} - 16'h0001;
            assign bmatch = pin_if.bclk_rise[ch] &&
                            (bcnt_ff == cmp_ff[14:0]);
            // (RQ12) high compare-1
            assign hi_end = active & ~low_ff &
                (cmp_ff[`SCU_CMP_SYSCLK] ? (ph_ff == hi_len - 16'h0001)
                 : (dly_run_ff && dly_ff == 3'h1));
            // (RQ12) low two cycles
            assign lo_end = active & low_ff &
                            (ph_ff == `SCU_LOW_CYC - 16'h0001);
            assign rise = lo_end;
            // (RQ24) eight bit periods
            assign last = hi_end && (bits_ff == `SCU_BITS);
            // (RQ23) both empty
            assign empty = ~tfull_ff && (st_ff != SCU_TX) &&
                           (st_ff != SCU_CTSW);

            // Control register and compare register writes
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    mode_ff <= `SCU_MODE_SYNC;
                    ren_ff  <= 1'b0;
                    gate_ff <= 1'b0;
                    brk_ff  <= 1'b0;
                    cmp_ff  <= `SCU_CMP_RST;
                end else if (wr_en && paddr[4:2] == `SCU_OFS_CTRL) begin
                    // (RQ1) software set-up
                    mode_ff <= pwdata[2:0];
                    ren_ff  <= pwdata[`SCU_CTRL_REN];
                    gate_ff <= pwdata[`SCU_CTRL_GATE];
                    brk_ff  <= pwdata[`SCU_CTRL_BRK];
                end else if (wr_en && paddr[4:2] == `SCU_OFS_CMP) begin
                    cmp_ff <= pwdata[15:0];
                end
            end

            // Baud counter and low-start delay, baud clock timebase
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    bcnt_ff    <= 15'h0000;
                    dly_ff     <= 3'h0;
                    dly_run_ff <= 1'b0;
                end else begin
                    // (RQ9) count rises
                    if (bmatch) begin
                        bcnt_ff <= 15'h0000;
                    end else if (pin_if.bclk_rise[ch]) begin
                        bcnt_ff <= bcnt_ff + 15'h0001;
                    end
                    // (RQ16) delayed low start
                    if (bmatch && !cmp_ff[`SCU_CMP_SYSCLK]) begin
                        dly_ff     <= `SCU_BCLK_DLY;
                        dly_run_ff <= 1'b1;
                    end else if (dly_run_ff) begin
                        dly_ff     <= dly_ff - 3'h1;
                        dly_run_ff <= (dly_ff != 3'h1);
                    end
                end
            end

            // Holding buffer and clear-to-send arming
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    tbuf_ff  <= 8'h00;
                    tfull_ff <= 1'b0;
                    armed_ff <= 1'b0;
                end else if (wr_en && paddr[4:2] == `SCU_OFS_TBUF) begin
                    // (RQ2) write starts transfer
                    tbuf_ff  <= pwdata[7:0];
                    tfull_ff <= 1'b1;
                    // (RQ6) write arms sense
                    armed_ff <= 1'b1;
                end else if (nxt_st == SCU_TX && st_ff != SCU_TX) begin
                    tfull_ff <= 1'b0;
                    armed_ff <= 1'b0;
                end
            end

            // Sequencer next state
            always_comb begin
                nxt_st = st_ff;
                case (st_ff)
                    SCU_IDLE: begin
                        if (sync_mode && tfull_ff) begin
                            nxt_st = gate_ff ? SCU_CTSW : SCU_TX;
                        end else if (sync_mode && ren_ff && !rdn_ff[ch]) begin
                            // (RQ3) enable with flag clear
                            nxt_st = SCU_RX;
                        end
                    end
                    SCU_CTSW: begin
                        // (RQ6) live level only
                        if (armed_ff && pin_if.cts_lvl[ch]) begin
                            nxt_st = SCU_TX;
                        end
                    end
                    SCU_TX, SCU_RX: begin
                        if (last) begin
                            nxt_st = SCU_IDLE;
                        end
                    end
                    default: begin
                        nxt_st = SCU_IDLE;
                    end
                endcase
            end

            // Sequencer state
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    st_ff <= SCU_IDLE;
                end else begin
                    st_ff <= nxt_st;
                end
            end

            // Shift clock phase timer; starts in the high phase
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    low_ff <= 1'b0;
                    ph_ff  <= 16'h0000;
                end else if (!active || hi_end || lo_end) begin
                    low_ff <= active & hi_end;
                    ph_ff  <= 16'h0000;
                end else begin
                    ph_ff <= ph_ff + 16'h0001;
                end
            end

            // Shift register and bit count
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    sh_ff   <= 8'h00;
                    bits_ff <= 4'h0;
                end else if (!active) begin
                    sh_ff   <= (nxt_st == SCU_TX) ? tbuf_ff : 8'h00;
                    bits_ff <= 4'h0;
                end else if (rise) begin
                    // (RQ24) LSB first
                    bits_ff <= bits_ff + 4'h1;
                    sh_ff   <= (st_ff == SCU_RX) ?
                               {pin_if.rxd_lvl[ch], sh_ff[7:1]} :
                               {1'b0, sh_ff[7:1]};
                end
            end

            // Receive holding buffer
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    rbuf_ff <= 8'h00;
                end else if (st_ff == SCU_RX && last) begin
                    rbuf_ff <= sh_ff;
                end
            end

            // Done flags; hardware set wins over any clear
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    rdn_ff[ch] <= 1'b0;
                    tdn_ff[ch] <= 1'b0;
                end else begin
                    if (st_ff == SCU_RX && last) begin
                        // (RQ18) set on reception
                        rdn_ff[ch] <= 1'b1;
                    end else if (ch == 1 && rd_en &&
                                 paddr[4:2] == `SCU_OFS_STAT) begin
                        // (RQ21) read clears
                        rdn_ff[ch] <= 1'b0;
                    end else if (wr_en && paddr[4:2] == `SCU_OFS_STAT) begin
                        rdn_ff[ch] <= pwdata[`SCU_STAT_RDN];
                    end
                    if (st_ff == SCU_TX && last) begin
                        // (RQ19) set on transmission
                        tdn_ff[ch] <= 1'b1;
                    end else if (ch == 1 && rd_en &&
                                 paddr[4:2] == `SCU_OFS_STAT) begin
                        // (RQ21) read clears
                        tdn_ff[ch] <= 1'b0;
                    end else if (wr_en && paddr[4:2] == `SCU_OFS_STAT) begin
                        tdn_ff[ch] <= pwdata[`SCU_STAT_TDN];
                    end
                end
            end

            // Requests pulse on completion; flags never gate them
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    rx_req_ff[ch] <= 1'b0;
                    tx_req_ff[ch] <= 1'b0;
                end else begin
                    rx_req_ff[ch] <= (st_ff == SCU_RX) && last;
                    tx_req_ff[ch] <= (st_ff == SCU_TX) && last;
                end
            end

            // Pins, all moved on system clock edges only
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    txd_ff[ch]      <= 1'b1;
                    rxd_out_ff[ch]  <= 1'b1;
                    rxd_oe_n_ff[ch] <= 1'b1;
                    rise_d_ff       <= 1'b0;
                end else begin
                    // (RQ5) break overrides line only
                    // (RQ17) aligned edges, no low pulse at the end
                    txd_ff[ch] <= ~brk_ff & ~(active &
                                  ((hi_end & ~last) | (low_ff & ~lo_end)));
                    // (RQ11) RXD driven only transmitting
                    rxd_oe_n_ff[ch] <= (nxt_st != SCU_TX);
                    rise_d_ff       <= rise;
                    // (RQ14) data moves the cycle after the rise
                    if (nxt_st == SCU_TX && st_ff != SCU_TX) begin
                        rxd_out_ff[ch] <= tbuf_ff[0];
                    end else if (st_ff == SCU_TX && rise_d_ff) begin
                        rxd_out_ff[ch] <= sh_ff[0];
                    end
                end
            end

            // Read view; async error and break bits read zero
            // (RQ4) invalid flags zero
            always_comb begin
                rd_word[ch] = 32'h0000_0000;
                case (paddr[4:2])
                    `SCU_OFS_CTRL: begin
                        rd_word[ch][2:0] = mode_ff;
                        rd_word[ch][`SCU_CTRL_REN]  = ren_ff;
                        rd_word[ch][`SCU_CTRL_GATE] = gate_ff;
                        rd_word[ch][`SCU_CTRL_BRK]  = brk_ff;
                    end
                    `SCU_OFS_STAT: begin
                        rd_word[ch][`SCU_STAT_EMP] = empty;
                        rd_word[ch][`SCU_STAT_TDN] = tdn_ff[ch];
                        rd_word[ch][`SCU_STAT_RDN] = rdn_ff[ch];
                    end
                    `SCU_OFS_TBUF: rd_word[ch][7:0]  = tbuf_ff;
                    `SCU_OFS_RBUF: rd_word[ch][7:0]  = rbuf_ff;
                    `SCU_OFS_CMP:  rd_word[ch][15:0] = cmp_ff;
                    `SCU_OFS_CNT:  rd_word[ch][14:0] = bcnt_ff;
                    default:       rd_word[ch] = 32'h0000_0000;
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Channel one interrupt pin
    // ----------------------------------------------------------------
    // (RQ20) OR of both flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq1_ff <= 1'b0;
        end else begin
            irq1_ff <= rdn_ff[1] | tdn_ff[1];
        end
    end

    assign txd                    = txd_ff;
    assign rxd_out                = rxd_out_ff;
    assign rxd_oe_n               = rxd_oe_n_ff;
    assign rx_req0                = rx_req_ff[0];
    assign tx_req0                = tx_req_ff[0];
    assign second_channel_irq_out = irq1_ff;
endmodule // scu_top
